// [verilog/acf_defs.svh]
// Constants for the card-emulation anti-collision filter command block.
// Assumes inclusion by bare name from the design files.
`ifndef ACF_DEFS_SVH
`define ACF_DEFS_SVH
`define CMD_FILTER 8'h0D
`define CMD_LOOPBACK 8'h55
`define RES_OK 8'h00
`define RES_BAD_LEN 8'h82
`define LEN_ONE_CASCADE 8'h07
`define LEN_TWO_CASCADE 8'h0B
`define LEN_THREE_CASCADE 8'h0F
`define ST_IDLE 8'h00
`define ST_READY_A 8'h01
`define ST_READY_B 8'h02
`define ST_READY_C 8'h03
`define ST_ACTIVE 8'h04
`define ST_HALT 8'h80
`define ST_HALTED_READY_FIRST 8'h81
`define ST_HALTED_READY_B 8'h82
`define ST_HALTED_READY_C 8'h83
`define ST_HALTED_SELECTED 8'h84
`define HALT_BIT 7
`define SHORT_SENSE 8'h26
`define SHORT_WAKE 8'h52
`define SDD_LEVEL1 8'h93
`define SDD_LEVEL2 8'h95
`define SDD_LEVEL3 8'h97
`define SEL_NVB 8'h70
`endif

// [verilog/acf_pkg.sv]
// Types for the anti-collision filter command block.
// Assumes acf_defs.svh is on the include path.
`default_nettype none
package acf_pkg;
	// Command parser states
	typedef enum logic [2:0] {P_IDLE, P_LEN, P_BODY, P_EXEC, P_REPLY} parse_e;
endpackage
`default_nettype wire

// [verilog/card_state_check.sv]
// Checks whether a byte is one of the ten defined card state codes.
// Assumes pure combinational use by the command interpreter.
`include "acf_defs.svh"
`default_nettype none
module card_state_check
(
	// Byte under test
	input wire logic [7:0] code,
	// Result
	output logic legal
);
	logic [6:0] low;
	// Low part 0..4, with or without the halt bit
	always_comb
	begin
		low = code[6:0];
		legal = ({1'b0, low} <= `ST_ACTIVE);
	end
endmodule
`default_nettype wire

// [verilog/collision_filter.sv]
// Command interpreter for the card-emulation anti-collision filter and loopback.
// Assumes host bytes arrive as one-cycle strobes with a frame-start mark, and
// reader frames arrive whole as a 16-bit head with a byte count.
`include "acf_defs.svh"
`default_nettype none
module collision_filter
	import acf_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Host command bytes
	input wire logic cmd_valid,
	input wire logic cmd_first,
	input wire logic [7:0] cmd_byte,
	// Host reply bytes
	output logic rsp_valid,
	output logic [7:0] rsp_byte,
	// Listening mode
	input wire logic listen_start,
	output logic listening,
	// Reader frames
	input wire logic rx_valid,
	input wire logic rx_short,
	input wire logic [15:0] rx_head,
	input wire logic [4:0] rx_count,
	// Frame outputs
	output logic to_host,
	output logic local_answer,
	output logic [7:0] card_state,
	output logic filter_on
);
	// ************************************************************
	// Command parser
	// ************************************************************
	parse_e st_reg, st_next;
	logic [7:0] len_reg, len_next, cnt_reg, cnt_next;
	logic [7:0] arg_reg, arg_next;
	logic [7:0] r0_reg, r0_next, r1_reg, r1_next, r2_reg, r2_next;
	logic [2:0] nrsp_reg, nrsp_next, irsp_reg, irsp_next;
	logic [7:0] state_reg, state_next;
	logic filt_reg, filt_next, listen_reg, listen_next;
	logic out_v_reg, out_v_next;
	logic [7:0] out_b_reg, out_b_next;
	logic tohost_reg, tohost_next, local_reg, local_next;
	logic arg_legal, sdd, sel;

	card_state_check chk (.code(arg_reg), .legal(arg_legal));

	assign rsp_valid = out_v_reg;
	assign rsp_byte = out_b_reg;
	assign listening = listen_reg;
	assign to_host = tohost_reg;
	assign local_answer = local_reg;
	assign card_state = state_reg;
	assign filter_on = filt_reg;

	// Reader frame classification
	assign sdd = !rx_short && (rx_head[15:8] == `SDD_LEVEL1 || rx_head[15:8] == `SDD_LEVEL2
		|| rx_head[15:8] == `SDD_LEVEL3);
	assign sel = sdd && rx_head[7:0] == `SEL_NVB;

	// Next-state of parser, card state and frame routing
	always_comb
	begin
		st_next = st_reg;
		len_next = len_reg;
		cnt_next = cnt_reg;
		arg_next = arg_reg;
		r0_next = r0_reg;
		r1_next = r1_reg;
		r2_next = r2_reg;
		nrsp_next = nrsp_reg;
		irsp_next = irsp_reg;
		state_next = state_reg;
		filt_next = filt_reg;
		listen_next = listen_reg | listen_start;
		out_v_next = 1'b0;
		out_b_next = out_b_reg;
		tohost_next = 1'b0;
		local_next = 1'b0;
		unique case (st_reg)
			P_IDLE:
			begin
				if (cmd_valid && cmd_first)
				begin
					cnt_next = 8'h00;
					if (cmd_byte == `CMD_LOOPBACK)
					begin
						r0_next = `CMD_LOOPBACK;
						nrsp_next = 3'd1;
						irsp_next = 3'd0;
						// A listen request in the same cycle wins over the exit
						listen_next = listen_start;
						st_next = P_REPLY;
					end
					else if (cmd_byte == `CMD_FILTER)
						st_next = P_LEN;
				end
			end
			P_LEN:
			begin
				if (cmd_valid)
				begin
					len_next = cmd_byte;
					st_next = (cmd_byte == 8'h00) ? P_EXEC : P_BODY;
				end
			end
			P_BODY:
			begin
				if (cmd_valid)
				begin
					// Keep the first byte; later bytes are counted only
					if (cnt_reg == 8'h00)
						arg_next = cmd_byte;
					cnt_next = cnt_reg + 8'h01;
					if (cnt_reg + 8'h01 == len_reg)
						st_next = P_EXEC;
				end
			end
			P_EXEC:
			begin
				irsp_next = 3'd0;
				r0_next = `RES_OK;
				r1_next = 8'h00;
				nrsp_next = 3'd2;
				st_next = P_REPLY;
				if (len_reg == 8'h00)
				begin
					filt_next = 1'b0;
					r1_next = 8'h01;
					r2_next = state_reg;
					nrsp_next = 3'd3;
				end
				else if (len_reg == 8'h01)
				begin
					if (arg_legal)
						state_next = arg_reg;
					else
						r0_next = `RES_BAD_LEN;
				end
				else if (len_reg == 8'h02)
				begin
					r1_next = 8'h01;
					r2_next = state_reg;
					nrsp_next = 3'd3;
				end
				else if (len_reg == `LEN_ONE_CASCADE || len_reg == `LEN_TWO_CASCADE
					|| len_reg == `LEN_THREE_CASCADE)
				begin
					filt_next = 1'b1;
					state_next = `ST_IDLE;
				end
				else
					r0_next = `RES_BAD_LEN;
			end
			P_REPLY:
			begin
				out_v_next = 1'b1;
				out_b_next = (irsp_reg == 3'd0) ? r0_reg : (irsp_reg == 3'd1) ? r1_reg : r2_reg;
				irsp_next = irsp_reg + 3'd1;
				if (irsp_reg + 3'd1 == nrsp_reg)
					st_next = P_IDLE;
			end
		endcase
		// Reader frames: local answer or hand to host
		if (rx_valid)
		begin
			if (!filt_reg)
				tohost_next = 1'b1;
			else if (rx_short && (rx_head[7:0] == `SHORT_SENSE || rx_head[7:0] == `SHORT_WAKE))
			begin
				local_next = 1'b1;
				if (rx_head[7:0] == `SHORT_WAKE || !state_reg[`HALT_BIT])
					state_next = `ST_READY_A;
			end
			// A select past the last level is not ours; the host sees it
			else if (sel && rx_count == 5'd9 && state_reg[6:0] != 7'd0
				&& state_reg[6:0] < 7'(`ST_ACTIVE))
			begin
				local_next = 1'b1;
				state_next = {state_reg[7], 7'(state_reg[6:0] + 7'd1)};
			end
			else if (sdd && !sel && state_reg[6:0] != 7'd0)
				local_next = 1'b1;
			else
				tohost_next = 1'b1;
		end
	end

	// Register the whole group
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			st_reg <= P_IDLE;
			len_reg <= 8'h00;
			cnt_reg <= 8'h00;
			arg_reg <= 8'h00;
			r0_reg <= 8'h00;
			r1_reg <= 8'h00;
			r2_reg <= 8'h00;
			nrsp_reg <= 3'd0;
			irsp_reg <= 3'd0;
			state_reg <= `ST_IDLE;
			filt_reg <= 1'b0;
			listen_reg <= 1'b0;
			out_v_reg <= 1'b0;
			out_b_reg <= 8'h00;
			tohost_reg <= 1'b0;
			local_reg <= 1'b0;
		end
		else
		begin
			st_reg <= st_next;
			len_reg <= len_next;
			cnt_reg <= cnt_next;
			arg_reg <= arg_next;
			r0_reg <= r0_next;
			r1_reg <= r1_next;
			r2_reg <= r2_next;
			nrsp_reg <= nrsp_next;
			irsp_reg <= irsp_next;
			state_reg <= state_next;
			filt_reg <= filt_next;
			listen_reg <= listen_next;
			out_v_reg <= out_v_next;
			out_b_reg <= out_b_next;
			tohost_reg <= tohost_next;
			local_reg <= local_next;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	loopback_echo_a: assert property (@(posedge clk) disable iff (reset)
		st_reg == P_IDLE && cmd_valid && cmd_first && cmd_byte == `CMD_LOOPBACK
		|-> ##2 rsp_valid && rsp_byte == `CMD_LOOPBACK ##1 !rsp_valid)
		else $error("loopback reply wrong");
	loopback_unlisten_a: assert property (@(posedge clk) disable iff (reset)
		st_reg == P_IDLE && cmd_valid && cmd_first && cmd_byte == `CMD_LOOPBACK && !listen_start
		|=> !listening)
		else $error("listening not ended");
	filter_off_host_a: assert property (@(posedge clk) disable iff (reset)
		rx_valid && !filter_on |=> to_host && !local_answer)
		else $error("frame not passed to host");
	short_local_a: assert property (@(posedge clk) disable iff (reset)
		rx_valid && filter_on && rx_short && rx_head[7:0] == `SHORT_WAKE
		|=> local_answer && !to_host && card_state == `ST_READY_A)
		else $error("wake request not handled");
	deact_reply_a: assert property (@(posedge clk) disable iff (reset)
		st_reg == P_EXEC && len_reg == 8'h00
		|=> !filter_on ##1 rsp_byte == `RES_OK ##1 rsp_byte == 8'h01)
		else $error("deactivate reply wrong");
	bad_len_a: assert property (@(posedge clk) disable iff (reset)
		st_reg == P_EXEC && len_reg > 8'h02 && len_reg != `LEN_ONE_CASCADE
		&& len_reg != `LEN_TWO_CASCADE && len_reg != `LEN_THREE_CASCADE
		|=> ##1 rsp_byte == `RES_BAD_LEN ##1 rsp_byte == 8'h00 ##1 !rsp_valid)
		else $error("bad length not refused");
	activate_a: assert property (@(posedge clk) disable iff (reset)
		st_reg == P_EXEC && len_reg == `LEN_TWO_CASCADE
		|=> filter_on ##1 rsp_byte == `RES_OK ##1 rsp_byte == 8'h00)
		else $error("activation wrong");
	state_keep_a: assert property (@(posedge clk) disable iff (reset)
		st_reg == P_EXEC && len_reg == 8'h01 && !arg_legal && !rx_valid
		|=> $stable(card_state))
		else $error("illegal state accepted");
endmodule
`default_nettype wire

// [dv/host_model.sv]
// Host-side model: sends command frames byte by byte and gathers the replies.
// Assumes the block takes one byte per clock, marked at the frame start.
`default_nettype none
module host_model
(
	// Clock
	input wire logic clk,
	// Command bytes
	output logic cmd_valid,
	output logic cmd_first,
	output logic [7:0] cmd_byte,
	// Reply bytes
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_byte
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rx_q[$];
	initial
	begin
		cmd_valid = 1'b0;
		cmd_first = 1'b0;
		cmd_byte = 8'h00;
	end
	// Reply bytes are kept in arrival order
	always @(posedge clk)
		if (rsp_valid)
			rx_q.push_back(rsp_byte);
	// Bytes go out on consecutive edges; the idle data line shows the inverse
	task automatic send(input logic [7:0] b[$]);
		rx_q = {};
		foreach (b[i])
		begin
			@(posedge clk);
			cmd_valid <= 1'b1;
			cmd_first <= (i == 0);
			cmd_byte <= b[i];
		end
		@(posedge clk);
		cmd_valid <= 1'b0;
		cmd_first <= 1'b0;
		cmd_byte <= ~b[b.size() - 1];
	endtask
endmodule
`default_nettype wire

// [dv/tb_collision_filter.sv]
// Testbench for the anti-collision filter command block.
// Assumes the design files and host_model.sv are compiled before it.
`default_nettype none
module tb_collision_filter;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic cmd_valid, cmd_first, rsp_valid, listening, to_host, local_answer, filter_on;
	logic [7:0] cmd_byte, rsp_byte, card_state;
	logic listen_start = 1'b0;
	logic rx_valid = 1'b0;
	logic rx_short = 1'b0;
	logic [15:0] rx_head = 16'h0000;
	logic [4:0] rx_count = 5'h00;
	logic [31:0] rnd = 32'h89ed_4447;
	logic [7:0] q[$];
	logic [7:0] codes[10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04,
		8'h80, 8'h81, 8'h82, 8'h83, 8'h84};
	logic [7:0] lvl[3] = '{8'h93, 8'h95, 8'h97};
	int bad_count = 0;
	int checked = 0;
	int cyc = 0;
	always #20 clk = ~clk;
	collision_filter dut_u (.clk(clk), .reset(reset), .cmd_valid(cmd_valid),
		.cmd_first(cmd_first), .cmd_byte(cmd_byte), .rsp_valid(rsp_valid),
		.rsp_byte(rsp_byte), .listen_start(listen_start), .listening(listening),
		.rx_valid(rx_valid), .rx_short(rx_short), .rx_head(rx_head),
		.rx_count(rx_count), .to_host(to_host), .local_answer(local_answer),
		.card_state(card_state), .filter_on(filter_on));
	host_model host_u (.clk(clk), .cmd_valid(cmd_valid), .cmd_first(cmd_first),
		.cmd_byte(cmd_byte), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte));
	// ****************************************
	// Helpers
	// ****************************************
	// Next value of the stimulus sequence
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Byte comparison; flags are passed zero-extended
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	// Sends a command and compares length and content of the reply
	task automatic xfer(input logic [7:0] c[$], input logic [7:0] e[$]);
		host_u.send(c);
		repeat (e.size() + 4) @(posedge clk);
		chk(8'(host_u.rx_q.size()), 8'(e.size()));
		foreach (e[i])
			chk(host_u.rx_q[i], e[i]);
	endtask
	// One reader frame; the decision shows on the edge that takes it
	task automatic frame(input logic s, input logic [15:0] h, input logic [4:0] n,
		input logic loc);
		@(posedge clk);
		rx_valid <= 1'b1;
		rx_short <= s;
		rx_head <= h;
		rx_count <= n;
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_head <= ~h;
		#1;
		chk({7'h00, local_answer}, {7'h00, loc});
		chk({7'h00, to_host}, {7'h00, !loc});
	endtask
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Hang guard: the sequence needs well under a thousand cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			bad_count++;
			$display("[ERR] %0t timeout", $time);
			end_of_test();
		end
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		xfer({8'h55}, {8'h55});
		xfer({8'h0D, 8'h00}, {8'h00, 8'h01, 8'h00});
		// Each activation length, first cascade part always present
		for (int k = 7; k <= 15; k += 4)
		begin
			q = {8'h0D, 8'(k)};
			repeat (k)
			begin
				rnd = lfsr(rnd);
				q.push_back(rnd[7:0]);
			end
			xfer(q, {8'h00, 8'h00});
			chk({7'h00, filter_on}, 8'h01);
		end
		// Lengths between the legal ones, payload sent in full
		for (int k = 3; k < 15; k += 5)
		begin
			q = {8'h0D, 8'(k)};
			repeat (k)
				q.push_back(8'h00);
			xfer(q, {8'h82, 8'h00});
		end
		foreach (codes[j])
		begin
			xfer({8'h0D, 8'h01, codes[j]}, {8'h00, 8'h00});
			chk(card_state, codes[j]);
			xfer({8'h0D, 8'h02, 8'h00, 8'h00}, {8'h00, 8'h01, codes[j]});
			chk({7'h00, filter_on}, 8'h01);
		end
		xfer({8'h0D, 8'h01, 8'h05}, {8'h82, 8'h00});
		chk(card_state, 8'h84);
		// Full anticollision walk while listening, from a forced Idle
		xfer({8'h0D, 8'h01, 8'h00}, {8'h00, 8'h00});
		listen_start <= 1'b1;
		@(posedge clk);
		listen_start <= 1'b0;
		frame(1'b1, 16'h0026, 5'd1, 1'b1);
		chk(card_state, 8'h01);
		frame(1'b1, 16'h0052, 5'd1, 1'b1);
		foreach (lvl[j])
		begin
			frame(1'b0, {lvl[j], 8'h20}, 5'd2, 1'b1);
			frame(1'b0, {lvl[j], 8'h70}, 5'd9, 1'b1);
		end
		frame(1'b0, 16'h9770, 5'd9, 1'b0);
		rnd = lfsr(rnd);
		frame(1'b0, {8'h30, rnd[7:0]}, 5'd4, 1'b0);
		chk({7'h00, listening}, 8'h01);
		xfer({8'h55}, {8'h55});
		chk({7'h00, listening}, 8'h00);
		xfer({8'h0D, 8'h00}, {8'h00, 8'h01, 8'h04});
		// Mid-run reset: state back to Idle, first frame right after release
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		chk(card_state, 8'h00);
		frame(1'b1, 16'h0052, 5'd1, 1'b0);
		frame(1'b0, 16'h9370, 5'd9, 1'b0);
		end_of_test();
	end
endmodule
`default_nettype wire
